//--- rtl/rpu_pkg.sv
package rpu_pkg;
    // address and region geometry
    localparam int ADDR_W = 32;
    localparam int LIM_W = 33;
    localparam int MAX_REG = 32;
    localparam int IDX_W = 5;
    localparam int ENT_W = 6;
    localparam int N_ENT = 64;
    localparam int MIN_BYTES = 64;
    localparam int BYPASS_BIT = 31;

    // register byte offsets on the local port
    localparam int RA_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SEL = 8'h04;
    localparam logic [7:0] OFF_BASE = 8'h08;
    localparam logic [7:0] OFF_EXT_LO = 8'h0c;
    localparam logic [7:0] OFF_EXT_HI = 8'h10;
    localparam logic [7:0] OFF_ATTR = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFF_INFO = 8'h20;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int SEL_DATA_BIT = 5;
    localparam int ATTR_EN_BIT = 0;
    localparam int ATTR_USER_BIT = 1;
    localparam int ATTR_RX_BIT = 2;
    localparam int ATTR_W_BIT = 3;
    localparam int ATTR_C_BIT = 4;
    localparam int ATTR_W_ALL = 5;
    localparam int IRQ_W = 2;
    localparam int IRQ_IFAULT_BIT = 0;
    localparam int IRQ_DFAULT_BIT = 1;
    localparam int INFO_DCNT_LSB = 8;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [4:0] RST_ATTR = 5'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;

    typedef struct packed {
        logic valid;
        logic fetch;
        logic store;
        logic io;
        logic user;
        logic [31:0] addr;
    } rpu_req_s;

    typedef struct packed {
        logic valid;
        logic grant;
        logic fault;
        logic nomatch;
        logic cacheable;
        logic [5:0] region;
    } rpu_resp_s;
endpackage : rpu_pkg

//--- rtl/rpu_top.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - up to 32 instruction and 32 data regions
// - check every access when enabled, fault blocks it
// - regions apply to user or supervisor mode
// - index zero has highest priority per type
// - build parameter picks size or limit extent
// - size mode: address and mask equals base
// - limit mode: base <= address < limit
// - limit one bit wider than address
// - minimum region 64 bytes, parameter may raise
// - outside connected space matches no region
// - execute or read/write permission checked
// - no matching enabled region raises fault
// - data regions carry default cacheability
// - uncached io accesses always bypass cache
// - address bit 31 bypass stays operational
// - overlap resolved by lowest matching index
// - reset leaves protection disabled until enabled
module rpu_top #(
    parameter int N_IREG = 32,
    parameter int N_DREG = 32,
    parameter bit USE_LIMIT = 1'b0,
    parameter int MIN_SHIFT = 6,
    parameter logic [32:0] SPACE_END = 33'h1_0000_0000
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire rpu_pkg::rpu_req_s i_req,
    output rpu_pkg::rpu_resp_s o_resp,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output logic o_irq
);
    // region store: entries 0..31 instruction, 32..63 data
    logic [31:0] base [rpu_pkg::N_ENT];
    logic [32:0] ext [rpu_pkg::N_ENT];
    logic [4:0] attr [rpu_pkg::N_ENT];
    logic enable;
    logic [5:0] sel;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] next_rdata;
    rpu_pkg::rpu_resp_s next_resp;

    // register decode
    wire logic wr_ctrl = i_reg_wr && (i_reg_addr == rpu_pkg::OFF_CTRL);
    wire logic wr_sel = i_reg_wr && (i_reg_addr == rpu_pkg::OFF_SEL);
    wire logic wr_base = i_reg_wr && (i_reg_addr == rpu_pkg::OFF_BASE);
    wire logic wr_elo = i_reg_wr && (i_reg_addr == rpu_pkg::OFF_EXT_LO);
    wire logic wr_ehi = i_reg_wr && (i_reg_addr == rpu_pkg::OFF_EXT_HI);
    wire logic wr_attr = i_reg_wr && (i_reg_addr == rpu_pkg::OFF_ATTR);
    wire logic wr_stat = i_reg_wr && (i_reg_addr == rpu_pkg::OFF_IRQ_STAT);
    wire logic wr_mask = i_reg_wr && (i_reg_addr == rpu_pkg::OFF_IRQ_MASK);

    // a selected index beyond the configured count is not a region
    wire logic sel_data = sel[rpu_pkg::SEL_DATA_BIT];
    wire logic [4:0] sel_idx = sel[4:0];
    wire logic sel_ok = sel_data ? (32'(sel_idx) < N_DREG) : (32'(sel_idx) < N_IREG);

    // per-entry storage, written through the selector
    genvar g;
    generate
        for (g = 0; g < rpu_pkg::N_ENT; g++)
        begin : g_ent
            wire logic hit_sel = sel_ok && (sel == 6'(g));
            always_ff @(posedge i_clk)
            begin
                if (i_sys_rst)
                begin
                    base[g] <= rpu_pkg::RST_WORD;
                    ext[g] <= 33'h0_0000_0000;
                    attr[g] <= rpu_pkg::RST_ATTR;
                end
                else if (i_ce && hit_sel)
                begin
                    if (wr_base)
                        base[g] <= i_reg_wdata;
                    if (wr_elo)
                        ext[g][31:0] <= i_reg_wdata;
                    if (wr_ehi)
                        ext[g][32] <= i_reg_wdata[0];
                    if (wr_attr)
                        attr[g] <= i_reg_wdata[4:0];
                end
            end
        end
    endgenerate

    // low address bits below the minimum region size never take part
    localparam logic [31:0] LOW_MASK = 32'((33'h1 << MIN_SHIFT) - 33'h1);
    wire logic [31:0] req_a = i_req.addr & ~LOW_MASK;
    wire logic [32:0] req_a33 = {1'b0, req_a};
    // beyond the connected slaves nothing may match
    wire logic in_space = {1'b0, i_req.addr} < SPACE_END;
    wire logic req_data = !i_req.fetch;

    // match vector, one comparator per entry
    wire logic [63:0] match;
    generate
        for (g = 0; g < rpu_pkg::N_ENT; g++)
        begin : g_match
            localparam bit IS_DATA = (g >= rpu_pkg::MAX_REG);
            localparam int IDX = IS_DATA ? g - rpu_pkg::MAX_REG : g;
            localparam bit EXISTS = IS_DATA ? (IDX < N_DREG) : (IDX < N_IREG);
            wire logic [31:0] b = base[g] & ~LOW_MASK;
            wire logic [32:0] b33 = {1'b0, b};
            wire logic [32:0] lim = {ext[g][32], ext[g][31:0] & ~LOW_MASK};
            // limit compare is slower and larger but gives finer sizes
            wire logic m_lim = (req_a33 >= b33) && (req_a33 < lim);
            wire logic m_size = ((req_a & ext[g][31:0]) == b);
            wire logic m_addr = USE_LIMIT ? m_lim : m_size;
            assign match[g] = EXISTS && attr[g][rpu_pkg::ATTR_EN_BIT] && in_space
                && (IS_DATA == req_data) && m_addr;
        end
    endgenerate

    // lowest index wins within the type, searched from the top down
    logic hit;
    logic [5:0] hit_ent;
    always_comb
    begin
        hit = 1'b0;
        hit_ent = 6'h00;
        for (int i = rpu_pkg::N_ENT - 1; i >= 0; i--)
        begin
            if (match[i])
            begin
                hit = 1'b1;
                hit_ent = 6'(i);
            end
        end
    end

    // permission and cacheability of the winning region
    wire logic [4:0] hit_attr = attr[hit_ent];
    wire logic mode_ok = !i_req.user || hit_attr[rpu_pkg::ATTR_USER_BIT];
    wire logic perm_ok = i_req.store ? hit_attr[rpu_pkg::ATTR_W_BIT]
        : hit_attr[rpu_pkg::ATTR_RX_BIT];
    wire logic allow = hit && mode_ok && perm_ok;
    // io accesses and the top-bit window bypass whatever the region says
    wire logic bypass = i_req.io || i_req.addr[rpu_pkg::BYPASS_BIT];
    wire logic reg_cache = hit_attr[rpu_pkg::ATTR_C_BIT] && req_data && hit;
    wire logic chk_fault = enable && !allow;

    // answer of the checker, shown one cycle after the request
    always_comb
    begin
        next_resp.valid = i_req.valid;
        next_resp.grant = i_req.valid && !chk_fault;
        next_resp.fault = i_req.valid && chk_fault;
        next_resp.nomatch = i_req.valid && enable && !hit;
        next_resp.cacheable = i_req.valid && req_data && !bypass
            && (enable ? reg_cache : 1'b1);
        next_resp.region = enable ? hit_ent : 6'h00;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_resp <= '0;
        else if (i_ce)
            o_resp <= next_resp;
    end

    // fault events, set wins over a software clear in the same cycle
    wire logic ev_if = next_resp.fault && i_req.fetch;
    wire logic ev_df = next_resp.fault && !i_req.fetch;
    wire logic [1:0] ev = {ev_df, ev_if};
    wire logic [1:0] clr = wr_stat ? i_reg_wdata[1:0] : 2'h0;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            enable <= 1'b0;
            sel <= 6'h00;
            irq_stat <= rpu_pkg::RST_IRQ;
            irq_mask <= rpu_pkg::RST_IRQ;
            o_irq <= 1'b0;
        end
        else if (i_ce)
        begin
            if (wr_ctrl)
                enable <= i_reg_wdata[rpu_pkg::CTRL_EN_BIT];
            if (wr_sel)
                sel <= i_reg_wdata[5:0];
            if (wr_mask)
                irq_mask <= i_reg_wdata[1:0];
            irq_stat <= (irq_stat & ~clr) | ev;
            o_irq <= |(((irq_stat & ~clr) | ev) & (wr_mask ? i_reg_wdata[1:0] : irq_mask));
        end
    end

    // read mux; an unmapped offset reads as zero
    wire logic [31:0] info = {16'h0000, 8'(N_DREG), 8'(N_IREG)};
    wire logic [4:0] sel_attr = sel_ok ? attr[sel] : 5'h00;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (i_reg_addr)
            rpu_pkg::OFF_CTRL: next_rdata = {31'h0, enable};
            rpu_pkg::OFF_SEL: next_rdata = {26'h0, sel};
            rpu_pkg::OFF_BASE: next_rdata = sel_ok ? base[sel] : 32'h0;
            rpu_pkg::OFF_EXT_LO: next_rdata = sel_ok ? ext[sel][31:0] : 32'h0;
            rpu_pkg::OFF_EXT_HI: next_rdata = {31'h0, sel_ok && ext[sel][32]};
            rpu_pkg::OFF_ATTR: next_rdata = {27'h0, sel_attr};
            rpu_pkg::OFF_IRQ_STAT: next_rdata = {30'h0, irq_stat};
            rpu_pkg::OFF_IRQ_MASK: next_rdata = {30'h0, irq_mask};
            rpu_pkg::OFF_INFO: next_rdata = info;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // read data only stands in the cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_reg_rdata <= 32'h0000_0000;
        else if (i_ce)
            o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0000_0000;
    end

    // checking aids: sampled request and clock enable of the previous cycle
    logic p_ce;
    logic p_en;
    logic p_hit;
    logic p_allow;
    logic p_rd;
    rpu_pkg::rpu_req_s p_req;
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            p_ce <= 1'b0;
            p_en <= 1'b0;
            p_hit <= 1'b0;
            p_allow <= 1'b0;
            p_req <= '0;
            p_rd <= 1'b0;
        end
        else
        begin
            p_ce <= i_ce;
            p_en <= enable;
            p_hit <= hit;
            p_allow <= allow;
            p_req <= i_req;
            p_rd <= i_reg_rd;
        end
    end

    AST_DISABLED_PASS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && !p_en && p_req.valid |-> o_resp.grant && !o_resp.fault)
        else $error("disabled unit refused an access");

    AST_FAULT_BLOCKS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_resp.fault |-> !o_resp.grant && o_resp.valid)
        else $error("faulting access was granted");

    AST_NOMATCH_FAULT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && p_en && p_req.valid && !p_hit |-> o_resp.fault && o_resp.nomatch)
        else $error("unmatched access not faulted");

    AST_OUT_OF_SPACE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && p_en && p_req.valid && ({1'b0, p_req.addr} >= SPACE_END) |-> o_resp.fault && o_resp.nomatch)
        else $error("address outside space was not refused as unmatched");

    AST_IO_UNCACHED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && p_req.valid && p_req.io |-> !o_resp.cacheable)
        else $error("io access marked cacheable");

    AST_BIT31_BYPASS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && p_req.valid && p_req.addr[31] |-> !o_resp.cacheable)
        else $error("top bit window marked cacheable");

    AST_FETCH_NOCACHE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && p_req.valid && p_req.fetch |-> !o_resp.cacheable)
        else $error("instruction fetch marked cacheable");

    AST_LOWEST_WINS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        hit |-> ((match & ((64'h1 << hit_ent) - 64'h1)) == 64'h0) && match[hit_ent])
        else $error("winning region is not the lowest match");

    AST_RESET_OFF: assert property (@(posedge i_clk)
        $fell(i_sys_rst) |-> !enable && !o_irq)
        else $error("unit not disabled after reset");

    AST_USER_DENIED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && p_en && p_req.valid && p_req.user && !p_allow |-> o_resp.fault && !o_resp.grant)
        else $error("refused user access was not faulted");

    AST_FAULT_IRQ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && o_resp.fault && (irq_mask == 2'h3) && i_ce && !wr_mask && !wr_stat |=> o_irq)
        else $error("fault with open mask gave no interrupt");

    // a frozen clock enable must hold every registered output
    AST_CE_HOLDS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_ce |=> $stable(o_resp) && $stable(o_irq) && $stable(o_reg_rdata))
        else $error("outputs moved while the clock enable was low");

    AST_DISABLED_REGION: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && !p_en && p_req.valid |-> (o_resp.region == 6'h00) && !o_resp.nomatch)
        else $error("disabled unit reported a region");

    AST_DISABLED_CACHE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && !p_en && p_req.valid && !p_req.fetch && !p_req.io && !p_req.addr[31] |-> o_resp.cacheable)
        else $error("plain data access not cacheable while disabled");

    AST_GRANT_HIT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && p_en && o_resp.grant |-> p_hit && !o_resp.nomatch)
        else $error("access granted without a matching region");

    // read data may stand only in the cycle right after a read strobe
    AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && !p_rd |-> o_reg_rdata == 32'h0000_0000)
        else $error("read data stands without a read");

    AST_STAT_SETS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        p_ce && o_resp.fault |-> (p_req.fetch ? irq_stat[0] : irq_stat[1]))
        else $error("fault did not set its status bit");

    AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_irq == |(irq_stat & irq_mask))
        else $error("interrupt line disagrees with status and mask");

    COV_GRANTED: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        p_en && o_resp.grant && o_resp.cacheable);
    COV_PERM_FAULT: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        o_resp.fault && !o_resp.nomatch);
    COV_MISS_FAULT: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        o_resp.fault && o_resp.nomatch ##1 o_irq);
    COV_OVERLAP: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        hit && ($countones(match) > 1));
    COV_CE_FREEZE: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_ce && i_reg_wr);
endmodule : rpu_top

//--- bench/rpu_core_model.sv
`timescale 1ns/1ps
// stands in for the fetch and load/store stages, one access at a time
module rpu_core_model (
    input wire logic i_clk,
    input wire rpu_pkg::rpu_resp_s i_resp_a,
    input wire rpu_pkg::rpu_resp_s i_resp_b,
    output rpu_pkg::rpu_req_s o_req
);
    initial o_req = '0;

    // kind is {fetch, store, io, user}; answer taken one edge after the request
    // idle address is inverted so a stale request never looks like a live one
    task automatic access(input logic [3:0] kind, input logic [31:0] addr,
                          output rpu_pkg::rpu_resp_s ra, output rpu_pkg::rpu_resp_s rb);
        @(posedge i_clk);
        o_req <= {1'b1, kind, addr};
        @(posedge i_clk);
        o_req <= {1'b0, kind, ~addr};
        #1;
        ra = i_resp_a;
        rb = i_resp_b;
    endtask : access
endmodule : rpu_core_model

//--- bench/tb_rpu_top.sv
`timescale 1ns/1ps
module tb_rpu_top;
    localparam logic [3:0] FET = 4'h8;
    localparam logic [3:0] LD = 4'h0;
    localparam logic [3:0] ST = 4'h4;
    localparam logic [3:0] IO = 4'h2;
    localparam logic [3:0] USR = 4'h1;
    logic clk;
    logic rst;
    logic ce;
    logic [7:0] ra;
    logic [31:0] wd;
    logic [31:0] wd_l;
    logic wr;
    logic rd;
    logic [31:0] rdat_s;
    logic [31:0] rdat_l;
    logic irq_s;
    logic irq_l;
    rpu_pkg::rpu_req_s req;
    rpu_pkg::rpu_resp_s resp_s;
    rpu_pkg::rpu_resp_s resp_l;
    int n_errors;
    int checked;

    // same traffic into a size-mode and a limit-mode build
    rpu_top #(.N_IREG(4), .SPACE_END(33'h0_f000_0000)) u_dut (
        .i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_req(req), .o_resp(resp_s), .i_reg_addr(ra),
        .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat_s), .o_irq(irq_s));
    rpu_top #(.N_IREG(4), .USE_LIMIT(1'b1), .SPACE_END(33'h0_f000_0000)) u_dut_lim (
        .i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_req(req), .o_resp(resp_l), .i_reg_addr(ra),
        .i_reg_wdata(wd_l), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat_l), .o_irq(irq_l));
    rpu_core_model u_core (.i_clk(clk), .i_resp_a(resp_s), .i_resp_b(resp_l), .o_req(req));

    task automatic complete_run;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        checked++;
        if (got !== e)
        begin
            n_errors++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : chk

    // cacheability of a refused access is a don't-care
    task automatic chk_resp(input rpu_pkg::rpu_resp_s got, input rpu_pkg::rpu_resp_s e);
        rpu_pkg::rpu_resp_s g2;
        g2 = got;
        if (e.fault)
            g2.cacheable = e.cacheable;
        checked++;
        if (g2 !== e)
        begin
            n_errors++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : chk_resp

    // dl differs from d only where the limit build reads the extent
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [31:0] dl);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wd_l <= dl;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdat_s, e);
        chk(rdat_l, e);
    endtask : rd_reg

    task automatic chk_irq(input logic e);
        chk({31'h0, irq_s}, {31'h0, e});
        chk({31'h0, irq_l}, {31'h0, e});
    endtask : chk_irq

    task automatic region(input logic [31:0] sel, input logic [31:0] base, input logic [31:0] mask,
                          input logic [32:0] lim, input logic [31:0] attr);
        wr_reg(rpu_pkg::OFF_SEL, sel, sel);
        wr_reg(rpu_pkg::OFF_BASE, base, base);
        wr_reg(rpu_pkg::OFF_EXT_LO, mask, lim[31:0]);
        wr_reg(rpu_pkg::OFF_EXT_HI, 32'h0, {31'h0, lim[32]});
        wr_reg(rpu_pkg::OFF_ATTR, attr, attr);
    endtask : region

    task automatic acc(input logic [3:0] k, input logic [31:0] a, input logic g, input logic nm,
                       input logic c, input logic [5:0] r);
        rpu_pkg::rpu_resp_s e;
        rpu_pkg::rpu_resp_s rs;
        rpu_pkg::rpu_resp_s rl;
        e = '0;
        e.valid = 1'b1;
        e.grant = g;
        e.fault = !g;
        e.nomatch = nm;
        e.cacheable = c;
        e.region = r;
        u_core.access(k, a, rs, rl);
        chk_resp(rs, e);
        chk_resp(rl, e);
    endtask : acc

    // clock, 5 ns period
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // a hang counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial
    begin
        rst = 1'b1;
        ra = 8'h00;
        wd = 32'h0;
        wd_l = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        ce = 1'b1;
        n_errors = 0;
        checked = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(rpu_pkg::OFF_CTRL, 32'h0);
        // with the clock enable low the enabling write must not land
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(rpu_pkg::OFF_CTRL, 32'h1, 32'h1);
        ce <= 1'b1;
        rd_reg(rpu_pkg::OFF_CTRL, 32'h0);
        rd_reg(rpu_pkg::OFF_INFO, 32'h0000_2004);
        // disabled: everything passes
        acc(FET, 32'h0000_3000, 1, 0, 0, 6'h00);
        acc(LD, 32'h0000_4000, 1, 0, 1, 6'h00);
        acc(LD, 32'hf000_0040, 1, 0, 0, 6'h00);
        acc(LD | IO, 32'h0000_0040, 1, 0, 0, 6'h00);
        // bases aligned to their size before enabling
        region(32'h00, 32'h1000, 32'hffff_f000, 33'h0_0000_2000, 32'h05);
        region(32'h20, 32'h2000, 32'hffff_ffc0, 33'h0_0000_2040, 32'h01);
        region(32'h21, 32'h0000, 32'hffff_0000, 33'h0_0001_0000, 32'h1f);
        region(32'h22, 32'h0000, 32'h0000_0000, 33'h1_0000_0000, 32'h15);
        wr_reg(rpu_pkg::OFF_SEL, 32'h05, 32'h05);
        wr_reg(rpu_pkg::OFF_ATTR, 32'h1f, 32'h1f);
        rd_reg(rpu_pkg::OFF_ATTR, 32'h0);
        wr_reg(rpu_pkg::OFF_CTRL, 32'h1, 32'h1);
        rd_reg(rpu_pkg::OFF_CTRL, 32'h1);
        acc(FET, 32'h0000_1004, 1, 0, 0, 6'h00);
        acc(FET | USR, 32'h0000_1ffc, 0, 0, 0, 6'h00);
        acc(FET, 32'h0000_2000, 0, 1, 0, 6'h00);
        acc(FET, 32'h0000_0fc0, 0, 1, 0, 6'h00);
        acc(LD, 32'h0000_2010, 0, 0, 0, 6'h20);
        acc(LD, 32'h0000_203f, 0, 0, 0, 6'h20);
        acc(LD, 32'h0000_2040, 1, 0, 1, 6'h21);
        acc(LD | IO, 32'h0000_2040, 1, 0, 0, 6'h21);
        acc(ST | USR, 32'h0000_4000, 1, 0, 1, 6'h21);
        acc(LD | USR, 32'h0001_0000, 0, 0, 0, 6'h22);
        acc(LD, 32'h8000_4000, 1, 0, 0, 6'h22);
        acc(ST, 32'h9000_0000, 0, 0, 0, 6'h22);
        acc(LD, 32'hf000_0040, 0, 1, 0, 6'h00);
        // sticky status, mask, write-one-to-clear
        rd_reg(rpu_pkg::OFF_IRQ_STAT, 32'h3);
        chk_irq(1'b0);
        wr_reg(rpu_pkg::OFF_IRQ_MASK, 32'h3, 32'h3);
        chk_irq(1'b1);
        wr_reg(rpu_pkg::OFF_IRQ_STAT, 32'h1, 32'h1);
        chk_irq(1'b1);
        wr_reg(rpu_pkg::OFF_IRQ_MASK, 32'h1, 32'h1);
        chk_irq(1'b0);
        wr_reg(rpu_pkg::OFF_IRQ_STAT, 32'h2, 32'h2);
        rd_reg(rpu_pkg::OFF_IRQ_STAT, 32'h0);
        // a fault with the mask already open raises the line at once
        wr_reg(rpu_pkg::OFF_IRQ_MASK, 32'h3, 32'h3);
        acc(LD, 32'hf000_0040, 0, 1, 0, 6'h00);
        chk_irq(1'b1);
        rd_reg(rpu_pkg::OFF_IRQ_STAT, 32'h2);
        wr_reg(rpu_pkg::OFF_IRQ_STAT, 32'h2, 32'h2);
        rd_reg(8'h40, 32'h0);
        wr_reg(rpu_pkg::OFF_CTRL, 32'h0, 32'h0);
        acc(FET, 32'h0000_3000, 1, 0, 0, 6'h00);
        // a reset in mid-run turns protection off and clears the mask
        wr_reg(rpu_pkg::OFF_CTRL, 32'h1, 32'h1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(rpu_pkg::OFF_CTRL, 32'h0);
        rd_reg(rpu_pkg::OFF_IRQ_MASK, 32'h0);
        acc(LD, 32'h0000_4000, 1, 0, 1, 6'h00);
        complete_run();
    end
endmodule : tb_rpu_top
